// ==== rtl/sbi_irq_pulse.sv ====
// Top: interrupt pulse generator with AXI4-Lite register slave
// Summary of operation
// RULE1: In Normal or Stop the line is driven low for a fixed pulse time, then released, with a minimum high time between pulses.
// RULE2: Each status group is the OR of its bits and may start a pulse only when its mask bit is set.
// RULE3: Wake events raise a pulse only for inputs configured as wake sources.
// RULE4: The power-on flag, undervoltage, short, overvoltage and high thermal shutdown never start a pulse.
// RULE5: Pending failures left uncleared in Normal or Stop repeat the pulse periodically.
// RULE6: Only the serial-frame and checksum failure flags produce repeated pulses.
// RULE7: No pulse is driven in Restart, Fail-Safe or Sleep.
// RULE8: Entering Stop with any wake bit or brake overvoltage flag still set issues a pulse.
// RULE9: The readable status is refreshed at each falling edge of a pulse.
// RULE10: Events stay in their status registers until the host clears them.
// RULE11: The host may read a status register twice to confirm the event has gone.
// RULE12: During Init the pin is an input that selects development mode.
// RULE13: Clearing the periodic enable stops repeated pulses.
// RULE14: Events arriving while the line is low merge into the current pulse.
// RULE15: The repetition period is a fixed internal interval set by a parameter.
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
module sbi_irq_pulse #(
  parameter int WAKE_W = 5,
  parameter int PULSE_CYC = sbi_pkg::PULSE_CYC,
  parameter int GAP_CYC = sbi_pkg::GAP_CYC,
  parameter int PERIOD_CYC = sbi_pkg::PERIOD_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Status sources, held until host clears them
  input wire logic [sbi_pkg::SUP_W-1:0] supStat,
  input wire logic [sbi_pkg::THERM_W-1:0] thermStat,
  input wire logic [sbi_pkg::BUS_W-1:0] busStat,
  input wire logic [sbi_pkg::HS_W-1:0] hsStat,
  input wire logic [sbi_pkg::DRAIN_SOURCE_OV_REG_W-1:0] drainSourceOvReg,
  input wire logic [sbi_pkg::BRK_W-1:0] brakeDsOvFlags,
  input wire logic [sbi_pkg::DEV_W-1:0] deviceStatusReg,
  input wire logic [WAKE_W-1:0] wakeStatusReg,
  input wire logic [2:0] mode,
  // Interrupt pin
  input wire logic irqPinIn,
  output logic irqOutN,
  output logic irqOutEn,
  // Status side effects
  output logic statusUpdate,
  output logic devModeReq,
  output logic irq,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int TW = sbi_pkg::TW;
  localparam int SRC_W = sbi_pkg::SUP_W + sbi_pkg::THERM_W +
    sbi_pkg::BUS_W + sbi_pkg::HS_W + sbi_pkg::DRAIN_SOURCE_OV_REG_W + 2;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == sbi_pkg::OFS_CTRL) || (a == sbi_pkg::OFS_GMASK) ||
      (a == sbi_pkg::OFS_WAKECFG) || (a == sbi_pkg::OFS_EVSTAT) ||
      (a == sbi_pkg::OFS_EVMASK) || (a == sbi_pkg::OFS_SNAP) ||
      (a == sbi_pkg::OFS_STATE);
  endfunction

  sbi_pkg::sbi_state_t state;
  logic periodicIrqEnable;
  logic [sbi_pkg::GRP_W-1:0] groupMask;
  logic [WAKE_W-1:0] wakeCfg;
  logic [sbi_pkg::EV_W-1:0] evStat;
  logic [sbi_pkg::EV_W-1:0] evMask;
  logic [sbi_pkg::GRP_W+WAKE_W-1:0] snap;
  logic [SRC_W-1:0] src, prevSrc, rise;
  logic [WAKE_W-1:0] prevWake;
  logic [2:0] prevMode;
  logic [sbi_pkg::GRP_W-1:0] groupLvl, groupRise;
  logic modeOk, failLvl, stopEvt, wakeRise, cycFire, cycArm;
  logic trig, pend, pulseDone, cycDone, startLow;
  logic pinS1, pinS2;
  logic awHeld, wHeld;
  logic [7:0] awAddr;
  logic [7:0] wByte;
  logic wLane0, doWrite;

  assign modeOk = (mode == sbi_pkg::M_NORMAL) ||
    (mode == sbi_pkg::M_STOP); // [RULE7]
  assign failLvl = deviceStatusReg[sbi_pkg::SPI_FAIL_BIT] |
    deviceStatusReg[sbi_pkg::CRC_FAIL_BIT];

  // Excluded supply and thermal bits are stripped here [RULE4]
  // Both failure bits kept apart so a second failure still triggers
  assign src = {deviceStatusReg[sbi_pkg::CRC_FAIL_BIT],
    deviceStatusReg[sbi_pkg::SPI_FAIL_BIT], drainSourceOvReg, hsStat,
    busStat, thermStat & ~sbi_pkg::THERM_EXCL,
    supStat & ~sbi_pkg::SUP_EXCL};
  assign rise = src & ~prevSrc;

  // Group levels and newly set bits per group
  always_comb begin
    groupLvl = {failLvl, |drainSourceOvReg, |hsStat, |busStat,
      |src[11:8], |src[7:0]}; // [RULE2]
    groupRise = {|rise[33:32], |rise[31:24], |rise[23:16],
      |rise[15:12], |rise[11:8], |rise[7:0]}; // [RULE2]
  end

  assign wakeRise = |(wakeStatusReg & ~prevWake & wakeCfg); // [RULE3]
  assign stopEvt = (mode == sbi_pkg::M_STOP) &&
    (prevMode != sbi_pkg::M_STOP) &&
    ((|wakeStatusReg) || (|brakeDsOvFlags)); // [RULE8]
  // Only the frame and checksum failures can repeat [RULE6]
  assign cycArm = periodicIrqEnable && modeOk && failLvl &&
    groupMask[sbi_pkg::G_SPI]; // [RULE13]
  assign cycFire = cycArm && cycDone; // [RULE5]
  assign trig = modeOk && ((|(groupRise & groupMask)) || wakeRise ||
    stopEvt || cycFire);
  assign startLow = (state == sbi_pkg::S_IDLE) && modeOk &&
    (trig || pend);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      prevSrc <= '0;
      prevWake <= '0;
      prevMode <= 3'h0;
    end else begin
      prevSrc <= src;
      prevWake <= wakeStatusReg;
      prevMode <= mode;
    end
  end

  // Pulse and gap timing
  sbi_timer #(.W(TW)) u_pulseTimer (
    .mclk(mclk),
    .reset(reset),
    .load(startLow || ((state == sbi_pkg::S_LOW) &&
      (pulseDone || !modeOk))),
    .loadVal(startLow ? TW'(PULSE_CYC) : TW'(GAP_CYC)),
    .done(pulseDone)
  );

  // Repetition period restarts whenever nothing is pending [RULE15]
  sbi_timer #(.W(TW)) u_cycTimer (
    .mclk(mclk),
    .reset(reset),
    .load(!cycArm || cycDone),
    .loadVal(TW'(PERIOD_CYC)),
    .done(cycDone)
  );

  // Pulse state machine
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state <= sbi_pkg::S_IDLE;
      irqOutN <= 1'b1;
      pend <= 1'b0;
    end else begin
      unique case (state)
        sbi_pkg::S_IDLE: begin
          if (startLow) begin
            state <= sbi_pkg::S_LOW;
            irqOutN <= 1'b0; // [RULE1]
            pend <= 1'b0;
          end
        end
        sbi_pkg::S_LOW: begin
          // Newer events fold into this pulse [RULE14]
          if (pulseDone || !modeOk) begin
            state <= sbi_pkg::S_GAP;
            irqOutN <= 1'b1; // [RULE1] [RULE7]
          end
        end
        sbi_pkg::S_GAP: begin
          // Events during the gap wait for its end [RULE1]
          if (trig) begin
            pend <= 1'b1;
          end
          if (pulseDone) begin
            state <= sbi_pkg::S_IDLE;
          end
        end
        default: begin
          state <= sbi_pkg::S_IDLE;
          irqOutN <= 1'b1;
          pend <= 1'b0;
        end
      endcase
    end
  end

  // Status refresh at the falling edge of the line
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      statusUpdate <= 1'b0;
      snap <= '0;
    end else begin
      statusUpdate <= startLow; // [RULE9]
      if (startLow) begin
        snap <= {wakeStatusReg & wakeCfg, groupLvl}; // [RULE9]
      end
    end
  end

  // Pin direction; the pin is sampled every cycle, devModeReq follows it only in Init
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pinS1 <= 1'b1;
      pinS2 <= 1'b1;
      irqOutEn <= 1'b0;
      devModeReq <= 1'b0;
    end else begin
      pinS1 <= irqPinIn;
      pinS2 <= pinS1;
      irqOutEn <= (mode != sbi_pkg::M_INIT); // [RULE12]
      if (mode == sbi_pkg::M_INIT) begin
        devModeReq <= !pinS2; // [RULE12]
      end
    end
  end

  // AXI4-Lite write channel
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 8'h00;
      wByte <= 8'h00;
      wLane0 <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sbi_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= {s_axi_awaddr[7:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wByte <= s_axi_wdata[7:0];
        wLane0 <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(awAddr) ? sbi_pkg::RESP_OKAY :
          sbi_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      periodicIrqEnable <= sbi_pkg::RST_CYC_EN;
      groupMask <= sbi_pkg::RST_GMASK;
      wakeCfg <= '0;
      evMask <= sbi_pkg::RST_EVMASK;
    end else if (doWrite && wLane0) begin
      if (awAddr == sbi_pkg::OFS_CTRL) begin
        periodicIrqEnable <= wByte[0]; // [RULE13]
      end
      if (awAddr == sbi_pkg::OFS_GMASK) begin
        groupMask <= wByte[sbi_pkg::GRP_W-1:0]; // [RULE2]
      end
      if (awAddr == sbi_pkg::OFS_WAKECFG) begin
        wakeCfg <= wByte[WAKE_W-1:0]; // [RULE3]
      end
      if (awAddr == sbi_pkg::OFS_EVMASK) begin
        evMask <= wByte[sbi_pkg::EV_W-1:0];
      end
    end
  end

  // Sticky event bits; a set in the clearing cycle wins [RULE10]
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      evStat <= '0;
      irq <= 1'b0;
    end else begin
      evStat <= (evStat & ~((doWrite && wLane0 &&
        awAddr == sbi_pkg::OFS_EVSTAT) ?
        wByte[sbi_pkg::EV_W-1:0] : {sbi_pkg::EV_W{1'b0}})) |
        {startLow && stopEvt, startLow && cycFire, startLow};
      irq <= |(evStat & evMask);
    end
  end

  // AXI4-Lite read channel
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= sbi_pkg::RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= mapped({s_axi_araddr[7:2], 2'b00}) ?
          sbi_pkg::RESP_OKAY : sbi_pkg::RESP_SLVERR;
        unique case ({s_axi_araddr[7:2], 2'b00})
          sbi_pkg::OFS_CTRL: s_axi_rdata <= {31'h0, periodicIrqEnable};
          sbi_pkg::OFS_GMASK: s_axi_rdata <= 32'(groupMask);
          sbi_pkg::OFS_WAKECFG: s_axi_rdata <= 32'(wakeCfg);
          sbi_pkg::OFS_EVSTAT: s_axi_rdata <= 32'(evStat);
          sbi_pkg::OFS_EVMASK: s_axi_rdata <= 32'(evMask);
          sbi_pkg::OFS_SNAP: s_axi_rdata <= 32'(snap);
          sbi_pkg::OFS_STATE: s_axi_rdata <= {25'h0, devModeReq,
            pend, irqOutN, state, 1'b0, pinS2};
          default: s_axi_rdata <= 32'h0;
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Checks: cycle counters for low and high time
  logic [TW-1:0] lowCnt, highCnt;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      lowCnt <= '0;
      highCnt <= TW'(GAP_CYC);
    end else begin
      lowCnt <= irqOutN ? '0 : lowCnt + 1'b1;
      if (!irqOutN) begin
        highCnt <= '0;
      end else if (highCnt < TW'(GAP_CYC)) begin
        highCnt <= highCnt + 1'b1;
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  property p_pulseLen; // [RULE1]
    $rose(irqOutN) && $past(modeOk) |-> lowCnt == TW'(PULSE_CYC);
  endproperty
  a_pulseLen: assert property (p_pulseLen)
    else $error("pulse length wrong");

  property p_gap; // [RULE1]
    $fell(irqOutN) |-> highCnt >= TW'(GAP_CYC);
  endproperty
  a_gap: assert property (p_gap) else $error("gap too short");

  property p_modeBlock; // [RULE7]
    !modeOk && !irqOutN |=> irqOutN;
  endproperty
  a_modeBlock: assert property (p_modeBlock)
    else $error("line low in blocked mode");

  property p_init; // [RULE12]
    mode == sbi_pkg::M_INIT |=> !irqOutEn;
  endproperty
  a_init: assert property (p_init) else $error("pin driven in init");

  property p_refresh; // [RULE9]
    statusUpdate == $fell(irqOutN);
  endproperty
  a_refresh: assert property (p_refresh)
    else $error("refresh not at falling edge");

  property p_stopEntry; // [RULE8]
    stopEvt && state == sbi_pkg::S_IDLE |=> !irqOutN ##1 !irqOutN;
  endproperty
  a_stopEntry: assert property (p_stopEntry)
    else $error("no pulse on stop entry");

  property p_cycOff; // [RULE13]
    !periodicIrqEnable && $past(!periodicIrqEnable) |-> !cycDone;
  endproperty
  a_cycOff: assert property (p_cycOff)
    else $error("repeat while disabled");

  property p_merge; // [RULE14]
    state == sbi_pkg::S_LOW && trig |=> !pend;
  endproperty
  a_merge: assert property (p_merge) else $error("event not merged");

  property p_gate; // [RULE2]
    state == sbi_pkg::S_IDLE && !pend && groupMask == '0 &&
      wakeCfg == '0 && !stopEvt |=> irqOutN;
  endproperty
  a_gate: assert property (p_gate) else $error("masked group fired");

  c_pulse: cover property ($rose(irqOutN) ##[1:1000] $fell(irqOutN));
  c_cyc: cover property (cycFire && state == sbi_pkg::S_IDLE);
  c_stop: cover property (stopEvt);
  c_pendGap: cover property (state == sbi_pkg::S_GAP && trig);
endmodule

// ==== rtl/sbi_pkg.sv ====
// Package: constants and types of the interrupt pulse logic
package sbi_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int IRQ_PULSE_TIME_NS = 100000;
  localparam int IRQ_MIN_GAP_TIME_NS = 10000;
  localparam int CYC_PERIOD_NS = 10000000;
  localparam int PULSE_CYC =
    (IRQ_PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_CYC =
    (IRQ_MIN_GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PERIOD_CYC = CYC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TW = 24;

  // Source vector widths and excluded bits
  localparam int SUP_W = 8;
  localparam int THERM_W = 4;
  localparam int BUS_W = 4;
  localparam int HS_W = 8;
  localparam int DRAIN_SOURCE_OV_REG_W = 8;
  localparam int DEV_W = 8;
  localparam int BRK_W = 4;
  localparam logic [7:0] SUP_EXCL = 8'h0F;
  localparam logic [3:0] THERM_EXCL = 4'h8;
  localparam int SPI_FAIL_BIT = 0;
  localparam int CRC_FAIL_BIT = 1;

  // Group positions in the group mask
  localparam int G_SUP = 0;
  localparam int G_TEMP = 1;
  localparam int G_BUS = 2;
  localparam int G_HS = 3;
  localparam int G_BD = 4;
  localparam int G_SPI = 5;
  localparam int GRP_W = 6;

  // Event status bits
  localparam int EV_PULSE = 0;
  localparam int EV_CYC = 1;
  localparam int EV_STOP = 2;
  localparam int EV_W = 3;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_GMASK = 8'h04;
  localparam logic [7:0] OFS_WAKECFG = 8'h08;
  localparam logic [7:0] OFS_EVSTAT = 8'h0C;
  localparam logic [7:0] OFS_EVMASK = 8'h10;
  localparam logic [7:0] OFS_SNAP = 8'h14;
  localparam logic [7:0] OFS_STATE = 8'h18;

  // Reset values
  localparam logic RST_CYC_EN = 1'b1;
  localparam logic [5:0] RST_GMASK = 6'h3F;
  localparam logic [2:0] RST_EVMASK = 3'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    M_INIT = 3'b000, M_NORMAL = 3'b001, M_STOP = 3'b010,
    M_SLEEP = 3'b011, M_RESTART = 3'b100, M_FAILSAFE = 3'b101
  } sbi_mode_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00, S_LOW = 2'b01, S_GAP = 2'b10
  } sbi_state_t;
endpackage

// ==== rtl/sbi_timer.sv ====
// Reloadable down counter flagging its last cycle
module sbi_timer #(
  parameter int W = 24
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Control
  input wire logic load,
  input wire logic [W-1:0] loadVal,
  output logic done
);
  logic [W-1:0] cnt;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cnt <= '0;
    end else if (load) begin
      cnt <= loadVal;
    end else if (cnt != '0) begin
      cnt <= cnt - 1'b1;
    end
  end

  // Last cycle of the loaded interval
  assign done = (cnt == {{(W-1){1'b0}}, 1'b1});
endmodule

// ==== verification/sbi_host_model.sv ====
// Host side model: drives the pin in Init and watches interrupt pulses
module sbi_host_model (
  // Clock
  input wire logic mclk,
  // Interrupt pin
  input wire logic irqOutN,
  input wire logic irqOutEn,
  input wire logic devSelN,
  output logic irqPinIn,
  // Observation
  input wire logic statusUpdate,
  output int pulseCount,
  output int updCount,
  output int lowLen
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pinPrev = 1'h1;
  int lowRun = 0;
  // Host drives the select level only while the device lets go
  assign irqPinIn = irqOutEn ? irqOutN : devSelN;
  initial begin
    pulseCount = 0;
    updCount = 0;
    lowLen = 0;
  end
  always @(posedge mclk) begin
    pinPrev <= irqPinIn | ~irqOutEn;
    if (statusUpdate)
      updCount <= updCount + 1;
    if (pinPrev && irqOutEn && !irqPinIn)
      pulseCount <= pulseCount + 1;
    if (irqOutEn && !irqPinIn)
      lowRun <= lowRun + 1;
    else if (lowRun != 0) begin
      lowLen <= lowRun;
      lowRun <= 0;
    end
  end
endmodule

// ==== verification/tb.sv ====
// Testbench of the interrupt pulse logic
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PULSE = 8;
  logic mclk = 1'h0;
  logic reset = 1'h1;
  logic [7:0] supStat = 8'h00, hsStat = 8'h00, devStat = 8'h00;
  logic [7:0] drain_source_ov_reg = 8'h00;
  logic [3:0] thermStat = 4'h0, busStat = 4'h0, brake = 4'h0;
  logic [4:0] wake = 5'h00;
  logic [2:0] mode = 3'h0;
  logic devSelN = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd;
  logic irqPinIn, irqOutN, irqOutEn, statusUpdate, devModeReq, irq;
  int pulseCount, updCount, lowLen, p0 = 0, u0 = 0;
  int fail_count = 0;
  int samples_checked = 0;
  logic [31:0] rnd = 32'h2007727E;
  logic [7:0] ofs [6] = '{sbi_pkg::OFS_CTRL, sbi_pkg::OFS_GMASK,
    sbi_pkg::OFS_WAKECFG, sbi_pkg::OFS_EVSTAT, sbi_pkg::OFS_EVMASK, 8'h1C};
  logic [31:0] rv [6] = '{32'(sbi_pkg::RST_CYC_EN), 32'(sbi_pkg::RST_GMASK),
    32'h0, 32'h0, 32'(sbi_pkg::RST_EVMASK), 32'h0};

  always #5 mclk = ~mclk;

  sbi_irq_pulse #(.PULSE_CYC(PULSE), .GAP_CYC(4), .PERIOD_CYC(64)) dut (
    .mclk(mclk), .reset(reset), .supStat(supStat), .thermStat(thermStat),
    .busStat(busStat), .hsStat(hsStat), .drainSourceOvReg(drain_source_ov_reg),
    .brakeDsOvFlags(brake), .deviceStatusReg(devStat),
    .wakeStatusReg(wake), .mode(mode), .irqPinIn(irqPinIn),
    .irqOutN(irqOutN), .irqOutEn(irqOutEn), .statusUpdate(statusUpdate),
    .devModeReq(devModeReq), .irq(irq), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  sbi_host_model host (.mclk(mclk), .irqOutN(irqOutN),
    .irqOutEn(irqOutEn), .devSelN(devSelN), .irqPinIn(irqPinIn),
    .statusUpdate(statusUpdate), .pulseCount(pulseCount),
    .updCount(updCount), .lowLen(lowLen));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic finish_test;
    if (fail_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic done;
    done = 1'h0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (int i = 0; i < 50 && !done; i++) begin
      @(posedge mclk);
      if (awready)
        awvalid <= 1'h0;
      if (wready)
        wvalid <= 1'h0;
      if (bvalid) begin
        rsp = bresp;
        bready <= 1'h0;
        done = 1'h1;
      end
    end
    if (!done) begin
      fail_count++;
      finish_test();
    end
  endtask

  task automatic axi_rd(input logic [7:0] a);
    logic done;
    done = 1'h0;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (int i = 0; i < 50 && !done; i++) begin
      @(posedge mclk);
      if (arready)
        arvalid <= 1'h0;
      if (rvalid) begin
        rd = rdata;
        rsp = rresp;
        rready <= 1'h0;
        done = 1'h1;
      end
    end
    if (!done) begin
      fail_count++;
      finish_test();
    end
  endtask

  // Count pulses since the last call, checked after n more cycles; a negative expectation only resyncs
  task automatic run(input int n, input int e);
    repeat (n) @(posedge mclk);
    if (e >= 0) begin
      chk(32'(pulseCount - p0), 32'(e));
      chk(32'(updCount - u0), 32'(e));
    end
    p0 = pulseCount;
    u0 = updCount;
  endtask

  initial begin
    repeat (4) @(posedge mclk);
    reset <= 1'h0;
    repeat (6) @(posedge mclk);
    chk(devModeReq, 1);
    chk(irqOutEn, 0);
    for (int i = 0; i < 6; i++) begin
      axi_rd(ofs[i]);
      chk(rd, rv[i]);
      chk(rsp, i == 5 ? sbi_pkg::RESP_SLVERR : sbi_pkg::RESP_OKAY);
    end
    axi_wr(8'h1C, 32'h1);
    chk(rsp, sbi_pkg::RESP_SLVERR);
    chk(irq, 0);
    devSelN <= 1'h1;
    mode <= 3'h1;
    repeat (6) @(posedge mclk);
    chk(irqOutEn, 1);
    chk(devModeReq, 1);
    run(1, -1);
    rnd = lfsr(rnd);
    hsStat <= rnd[7:0] | 8'h01;
    run(150, 1);
    chk(32'(lowLen), 32'(PULSE));
    hsStat <= 8'h00;
    repeat (2) @(posedge mclk);
    hsStat <= 8'h01;
    repeat (3) @(posedge mclk);
    hsStat <= 8'h03;
    run(40, 1);
    rnd = lfsr(rnd);
    supStat <= {4'h0, rnd[3:0] | 4'h1};
    thermStat <= 4'h8;
    run(30, 0);
    supStat <= {rnd[7:4] | 4'h1, rnd[3:0] | 4'h1};
    run(30, 1);
    axi_wr(sbi_pkg::OFS_GMASK, 32'h3B);
    busStat <= 4'h3;
    run(30, 0);
    axi_wr(sbi_pkg::OFS_GMASK, 32'h3F);
    busStat <= 4'h7;
    run(30, 1);
    drain_source_ov_reg <= 8'h40;
    run(30, 1);
    wake <= 5'h04;
    run(30, 0);
    wake <= 5'h00;
    axi_wr(sbi_pkg::OFS_WAKECFG, 32'h4);
    wake <= 5'h04;
    run(30, 1);
    wake <= 5'h00;
    brake <= 4'h2;
    run(20, 0);
    mode <= 3'h2;
    run(30, 1);
    brake <= 4'h0;
    mode <= 3'h1;
    devStat <= 8'h01;
    run(100, 2);
    axi_wr(sbi_pkg::OFS_CTRL, 32'h0);
    run(20, -1);
    run(150, 0);
    devStat <= 8'h03;
    run(150, 1);
    devStat <= 8'h00;
    axi_wr(sbi_pkg::OFS_CTRL, 32'h1);
    axi_wr(sbi_pkg::OFS_EVSTAT, 32'h7);
    axi_wr(sbi_pkg::OFS_EVMASK, 32'h1);
    chk(irq, 0);
    hsStat <= 8'h83;
    run(30, 1);
    chk(irq, 1);
    for (int k = 0; k < 2; k++) begin
      axi_rd(sbi_pkg::OFS_EVSTAT);
      chk(rd, 32'h1);
    end
    axi_rd(sbi_pkg::OFS_SNAP);
    chk(rd, 32'h1D);
    axi_wr(sbi_pkg::OFS_EVSTAT, 32'h1);
    axi_rd(sbi_pkg::OFS_EVSTAT);
    chk(rd, 32'h0);
    chk(irq, 0);
    // A pulse cut short by leaving Normal
    hsStat <= 8'h10;
    repeat (3) @(posedge mclk);
    mode <= 3'h3;
    run(20, 1);
    chk(32'(lowLen), 32'h3);
    hsStat <= 8'h00;
    for (int m = 3; m <= 5; m++) begin
      mode <= 3'(m);
      run(3, -1);
      hsStat <= 8'hFF;
      run(30, 0);
      hsStat <= 8'h00;
      mode <= 3'h1;
      run(20, 0);
    end
    axi_wr(sbi_pkg::OFS_GMASK, 32'h0);
    axi_wr(sbi_pkg::OFS_WAKECFG, 32'h0);
    hsStat <= 8'h55;
    run(30, 0);
    finish_test();
  end
endmodule
